// [src/oscillator_source_select.sv]
// Oscillator source selection, start-up timer and oscillator enables
// ***************************************************************
// ***************************************************************
`timescale 1ns/10ps
`default_nettype none
module oscillator_source_select (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic [2:0] oscillator_group_config_in,
  input wire logic [4:0] primary_mode_config_in,
  input wire logic [1:0] monitor_switch_config_in,
  input wire logic restart_in,
  input wire logic osc_tick_in,
  input wire logic secondary_crystal_enable_in,
  input wire logic pll_lock_raw_in,
  input wire logic watchdog_enable_in,
  input wire logic power_up_timer_done_in,
  input wire logic [3:0] rc_tune_field_in,
  input wire logic tune_write_in,
  input wire logic clock_edge_safe_in,
  output logic [2:0] current_group_select_out,
  output logic [2:0] next_group_select_out,
  output logic [1:0] pll_gain_out,
  output logic pll_from_fast_rc_out,
  output logic [1:0] output_pin_function_out,
  output logic input_pin_gpio_out,
  output logic clock_release_out,
  output logic secondary_crystal_run_out,
  output logic secondary_crystal_is_clock_out,
  output logic fast_rc_run_out,
  output logic slow_rc_run_out,
  output logic slow_rc_timers_clock_out,
  output logic pll_lock_out,
  output logic [3:0] rc_tune_field_out,
  output logic switching_enabled_out,
  output logic fail_safe_monitor_enabled_out
);
  // ***************************************************************
  // Input synchronisers
  // ***************************************************************
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic tick_prev_reg;
  wire logic [2:0] async_bus = {osc_tick_in, pll_lock_raw_in,
                                power_up_timer_done_in};

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      sync1_reg <= osc_select_pkg::SYNC_RESET;
      sync2_reg <= osc_select_pkg::SYNC_RESET;
      tick_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= async_bus;
      sync2_reg <= sync1_reg;
      tick_prev_reg <= sync2_reg[2];
    end
  end

  wire logic tick_rise = sync2_reg[2] & ~tick_prev_reg;
  wire logic lock_sync = sync2_reg[1];
  wire logic pu_timer_done_sync = sync2_reg[0];

  // ***************************************************************
  // Mode decode
  // ***************************************************************
  function automatic logic [1:0] pll_gain_of(input logic [2:0] grp,
                                             input logic [4:0] mode);
    if (grp != osc_select_pkg::GROUP_PLL) begin
      pll_gain_of = osc_select_pkg::PLL_OFF;
    end else if (mode == osc_select_pkg::MODE_FAST_RC_X4 ||
                 mode == osc_select_pkg::MODE_STD_XTAL_X4 ||
                 mode == osc_select_pkg::MODE_EXT_CLK_IO_X4 ||
                 mode == osc_select_pkg::MODE_HS2_X4 ||
                 mode == osc_select_pkg::MODE_HS3_X4) begin
      pll_gain_of = osc_select_pkg::PLL_X4;
    end else if (mode == osc_select_pkg::MODE_FAST_RC_X8 ||
                 mode == osc_select_pkg::MODE_STD_XTAL_X8 ||
                 mode == osc_select_pkg::MODE_EXT_CLK_IO_X8 ||
                 mode == osc_select_pkg::MODE_HS2_X8 ||
                 mode == osc_select_pkg::MODE_HS3_X8) begin
      pll_gain_of = osc_select_pkg::PLL_X8;
    end else if (mode == osc_select_pkg::MODE_FAST_RC_X16 ||
                 mode == osc_select_pkg::MODE_STD_XTAL_X16 ||
                 mode == osc_select_pkg::MODE_EXT_CLK_IO_X16 ||
                 mode == osc_select_pkg::MODE_HS2_X16 ||
                 mode == osc_select_pkg::MODE_HS3_X16) begin
      pll_gain_of = osc_select_pkg::PLL_X16;
    end else begin
      pll_gain_of = osc_select_pkg::PLL_OFF;
    end
  endfunction : pll_gain_of

  function automatic logic is_crystal(input logic [2:0] grp,
                                      input logic [4:0] mode);
    logic prim;
    prim = (grp == osc_select_pkg::GROUP_PRIMARY) ||
           (grp == osc_select_pkg::GROUP_PLL);
    is_crystal = (grp == osc_select_pkg::GROUP_SEC_CRYSTAL) ||
                 (prim && pll_gain_of(grp, mode) != osc_select_pkg::PLL_OFF
                  && (mode[4] || mode[3:2] == 2'h1)) ||
                 ((grp == osc_select_pkg::GROUP_PRIMARY) &&
                  (mode == osc_select_pkg::MODE_LOW_RANGE_XTAL ||
                   mode == osc_select_pkg::MODE_STD_XTAL ||
                   mode == osc_select_pkg::MODE_HIGH_SPEED));
  endfunction : is_crystal

  logic [2:0] cur_reg;
  logic [2:0] nxt_reg;
  logic [4:0] mode_reg;
  logic [1:0] msc_reg;

  wire logic [1:0] gain_now = pll_gain_of(cur_reg, mode_reg);
  wire logic fast_rc_pll = (cur_reg == osc_select_pkg::GROUP_PLL) &&
    (mode_reg == osc_select_pkg::MODE_FAST_RC_X4 ||
     mode_reg == osc_select_pkg::MODE_FAST_RC_X8 ||
     mode_reg == osc_select_pkg::MODE_FAST_RC_X16);
  wire logic gpio_mode =
    mode_reg == osc_select_pkg::MODE_EXT_CLK_IO ||
    mode_reg == osc_select_pkg::MODE_EXT_RC_IO ||
    mode_reg[4:2] == 3'h3 || fast_rc_pll;
  wire logic clkout_mode =
    (cur_reg == osc_select_pkg::GROUP_PRIMARY) &&
    (mode_reg == osc_select_pkg::MODE_EXT_CLK ||
     mode_reg == osc_select_pkg::MODE_EXT_RC);
  wire logic [1:0] pin_fn = gpio_mode ? osc_select_pkg::PIN_GPIO :
    (clkout_mode ? osc_select_pkg::PIN_CLK_OUT :
     osc_select_pkg::PIN_CRYSTAL);
  wire logic need_timer = is_crystal(cur_reg, mode_reg);
  wire logic monitor_on = (msc_reg == 2'h0);
  wire logic switch_on = ~msc_reg[1];
  wire logic sec_cur = (cur_reg == osc_select_pkg::GROUP_SEC_CRYSTAL);
  wire logic slow_cur = (cur_reg == osc_select_pkg::GROUP_SLOW_RC);
  wire logic fast_cur = (cur_reg == osc_select_pkg::GROUP_FAST_RC) ||
                        fast_rc_pll;

  // ***************************************************************
  // Configuration capture and start-up timer
  // ***************************************************************
  logic [osc_select_pkg::STARTUP_WIDTH-1:0] count_reg;
  logic release_reg;
  logic pu_timer_seen_reg;
  logic [3:0] tune_reg;
  logic [3:0] tune_pend_reg;
  logic tune_pend_valid_reg;

  wire logic count_done = count_reg == osc_select_pkg::STARTUP_LAST;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      cur_reg <= osc_select_pkg::GROUP_SEC_CRYSTAL;
      nxt_reg <= osc_select_pkg::GROUP_SEC_CRYSTAL;
      mode_reg <= osc_select_pkg::MODE_LOW_RANGE_XTAL;
      msc_reg <= 2'h2;
      count_reg <= '0;
      release_reg <= 1'b0;
      pu_timer_seen_reg <= 1'b0;
    end else if (restart_in) begin
      cur_reg <= oscillator_group_config_in;
      nxt_reg <= oscillator_group_config_in;
      mode_reg <= primary_mode_config_in;
      msc_reg <= monitor_switch_config_in;
      count_reg <= '0;
      release_reg <= 1'b0;
      pu_timer_seen_reg <= 1'b0;
    end else begin
      if (pu_timer_done_sync) begin
        pu_timer_seen_reg <= 1'b1;
      end
      if (!need_timer) begin
        release_reg <= 1'b1;
      end else if (tick_rise && !release_reg) begin
        count_reg <= count_reg + 10'h001;
        if (count_done) begin
          release_reg <= 1'b1;
        end
      end
    end
  end

  // Tune applied only at a safe clock point
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      tune_reg <= osc_select_pkg::TUNE_RESET;
      tune_pend_reg <= osc_select_pkg::TUNE_RESET;
      tune_pend_valid_reg <= 1'b0;
    end else begin
      if (tune_write_in) begin
        tune_pend_reg <= rc_tune_field_in;
        tune_pend_valid_reg <= 1'b1;
      end else if (tune_pend_valid_reg && clock_edge_safe_in) begin
        tune_reg <= tune_pend_reg;
        tune_pend_valid_reg <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Registered outputs
  // ***************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      current_group_select_out <= osc_select_pkg::GROUP_SEC_CRYSTAL;
      next_group_select_out <= osc_select_pkg::GROUP_SEC_CRYSTAL;
      pll_gain_out <= osc_select_pkg::PLL_OFF;
      pll_from_fast_rc_out <= 1'b0;
      output_pin_function_out <= osc_select_pkg::PIN_CRYSTAL;
      input_pin_gpio_out <= 1'b0;
      clock_release_out <= 1'b0;
      secondary_crystal_run_out <= 1'b0;
      secondary_crystal_is_clock_out <= 1'b0;
      fast_rc_run_out <= 1'b0;
      slow_rc_run_out <= 1'b1;
      slow_rc_timers_clock_out <= 1'b1;
      pll_lock_out <= 1'b0;
      rc_tune_field_out <= osc_select_pkg::TUNE_RESET;
      switching_enabled_out <= 1'b0;
      fail_safe_monitor_enabled_out <= 1'b0;
    end else begin
      current_group_select_out <= cur_reg;
      next_group_select_out <= nxt_reg;
      pll_gain_out <= gain_now;
      pll_from_fast_rc_out <= fast_rc_pll;
      output_pin_function_out <= pin_fn;
      input_pin_gpio_out <= 1'b0;
      clock_release_out <= release_reg;
      secondary_crystal_run_out <= secondary_crystal_enable_in;
      secondary_crystal_is_clock_out <=
        sec_cur && secondary_crystal_enable_in;
      fast_rc_run_out <= fast_cur;
      slow_rc_run_out <= !pu_timer_seen_reg || monitor_on ||
        watchdog_enable_in || slow_cur;
      slow_rc_timers_clock_out <= !pu_timer_seen_reg || monitor_on ||
        watchdog_enable_in || slow_cur;
      pll_lock_out <= lock_sync && (gain_now != osc_select_pkg::PLL_OFF);
      rc_tune_field_out <= tune_reg;
      switching_enabled_out <= switch_on;
      fail_safe_monitor_enabled_out <= monitor_on;
    end
  end
endmodule : oscillator_source_select
`default_nettype wire

// [src/osc_select_pkg.sv]
// Constants for the oscillator source selection block
package osc_select_pkg;
  // Oscillator groups
  localparam logic [2:0] GROUP_SEC_CRYSTAL = 3'h0;
  localparam logic [2:0] GROUP_FAST_RC = 3'h1;
  localparam logic [2:0] GROUP_SLOW_RC = 3'h2;
  localparam logic [2:0] GROUP_PRIMARY = 3'h3;
  localparam logic [2:0] GROUP_PLL = 3'h7;
  // Primary mode codes
  localparam logic [4:0] MODE_LOW_RANGE_XTAL = 5'h00;
  localparam logic [4:0] MODE_HIGH_SPEED = 5'h02;
  localparam logic [4:0] MODE_STD_XTAL = 5'h04;
  localparam logic [4:0] MODE_STD_XTAL_X4 = 5'h05;
  localparam logic [4:0] MODE_STD_XTAL_X8 = 5'h06;
  localparam logic [4:0] MODE_STD_XTAL_X16 = 5'h07;
  localparam logic [4:0] MODE_EXT_RC_IO = 5'h08;
  localparam logic [4:0] MODE_EXT_RC = 5'h09;
  localparam logic [4:0] MODE_EXT_CLK = 5'h0b;
  localparam logic [4:0] MODE_EXT_CLK_IO = 5'h0c;
  localparam logic [4:0] MODE_EXT_CLK_IO_X4 = 5'h0d;
  localparam logic [4:0] MODE_EXT_CLK_IO_X8 = 5'h0e;
  localparam logic [4:0] MODE_EXT_CLK_IO_X16 = 5'h0f;
  localparam logic [4:0] MODE_FAST_RC_X4 = 5'h01;
  localparam logic [4:0] MODE_FAST_RC_X8 = 5'h0a;
  localparam logic [4:0] MODE_FAST_RC_X16 = 5'h03;
  localparam logic [4:0] MODE_HS2_X4 = 5'h11;
  localparam logic [4:0] MODE_HS2_X8 = 5'h12;
  localparam logic [4:0] MODE_HS2_X16 = 5'h13;
  localparam logic [4:0] MODE_HS3_X4 = 5'h15;
  localparam logic [4:0] MODE_HS3_X8 = 5'h16;
  localparam logic [4:0] MODE_HS3_X16 = 5'h17;
  // PLL gain codes
  localparam logic [1:0] PLL_OFF = 2'h0;
  localparam logic [1:0] PLL_X4 = 2'h1;
  localparam logic [1:0] PLL_X8 = 2'h2;
  localparam logic [1:0] PLL_X16 = 2'h3;
  // Output pin functions
  localparam logic [1:0] PIN_CRYSTAL = 2'h0;
  localparam logic [1:0] PIN_GPIO = 2'h1;
  localparam logic [1:0] PIN_CLK_OUT = 2'h2;
  // Start-up timer, tune and synchroniser reset values
  localparam int STARTUP_WIDTH = 10;
  localparam logic [9:0] STARTUP_LAST = 10'h3ff;
  localparam logic [3:0] TUNE_RESET = 4'h0;
  localparam logic [2:0] SYNC_RESET = 3'h0;
endpackage : osc_select_pkg

// [tb/oscillator_source_select_checker.sv]
// Checker for the oscillator source selection block
`timescale 1ns/10ps
`default_nettype none
module oscillator_source_select_checker (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic [2:0] oscillator_group_config_in,
  input wire logic [4:0] primary_mode_config_in,
  input wire logic restart_in,
  input wire logic clock_edge_safe_in,
  input wire logic [2:0] current_group_select_out,
  input wire logic [2:0] next_group_select_out,
  input wire logic [1:0] pll_gain_out,
  input wire logic pll_from_fast_rc_out,
  input wire logic input_pin_gpio_out,
  input wire logic clock_release_out,
  input wire logic secondary_crystal_run_out,
  input wire logic secondary_crystal_is_clock_out,
  input wire logic fast_rc_run_out,
  input wire logic slow_rc_run_out,
  input wire logic pll_lock_out,
  input wire logic [3:0] rc_tune_field_out,
  input wire logic fail_safe_monitor_enabled_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  chk_input_never_gpio: assert property (!input_pin_gpio_out)
    else $error("input pin became general I/O");
  chk_group_loaded: assert property (restart_in |-> ##2
    current_group_select_out == $past(oscillator_group_config_in, 2))
    else $error("current group not loaded from config");
  chk_next_matches: assert property (restart_in |-> ##2
    next_group_select_out == current_group_select_out)
    else $error("next group differs from current");
  chk_fast_rc_gain: assert property (restart_in &&
    oscillator_group_config_in == 3'h7 && primary_mode_config_in == 5'h01
    |-> ##2 pll_gain_out == 2'h1 && pll_from_fast_rc_out)
    else $error("fast RC x4 not selected");
  chk_release_gated: assert property (restart_in |-> ##2 !clock_release_out)
    else $error("clock released too early after restart");
  chk_sec_clock_run: assert property (secondary_crystal_is_clock_out |->
    secondary_crystal_run_out && current_group_select_out == 3'h0)
    else $error("secondary crystal clock without run or group");
  chk_lock_masked: assert property (pll_lock_out |-> pll_gain_out != 2'h0)
    else $error("lock shown with PLL off");
  chk_fast_rc_runs: assert property (current_group_select_out == 3'h1 &&
    $stable(current_group_select_out) |-> fast_rc_run_out)
    else $error("fast RC stopped while selected");
  chk_monitor_slow: assert property (fail_safe_monitor_enabled_out &&
    $stable(fail_safe_monitor_enabled_out) |-> slow_rc_run_out)
    else $error("slow RC stopped with monitor on");
  chk_tune_when_safe: assert property ($changed(rc_tune_field_out) |->
    $past(clock_edge_safe_in) || $past(clock_edge_safe_in, 2))
    else $error("tune changed outside safe edge");
endmodule : oscillator_source_select_checker
bind oscillator_source_select oscillator_source_select_checker u_chk (.*);
`default_nettype wire

// [tb/oscillator_source_select_tb.sv]
// Self-checking testbench for the oscillator source selection block
`timescale 1ns/10ps
`default_nettype none
module oscillator_source_select_tb;
  logic clk_sys_in, rstn_in, restart_in, osc_tick_in, tune_write_in;
  logic secondary_crystal_enable_in, pll_lock_raw_in, watchdog_enable_in;
  logic power_up_timer_done_in, clock_edge_safe_in;
  logic [2:0] oscillator_group_config_in, current_group_select_out;
  logic [2:0] next_group_select_out;
  logic [4:0] primary_mode_config_in;
  logic [1:0] monitor_switch_config_in, pll_gain_out, output_pin_function_out;
  logic [3:0] rc_tune_field_in, rc_tune_field_out;
  logic pll_from_fast_rc_out, input_pin_gpio_out, clock_release_out;
  logic secondary_crystal_run_out, secondary_crystal_is_clock_out;
  logic fast_rc_run_out, slow_rc_run_out, slow_rc_timers_clock_out;
  logic pll_lock_out, switching_enabled_out, fail_safe_monitor_enabled_out;
  int bad_count = 0;
  int num_checks = 0;
  oscillator_source_select u_dut (.*);
  initial begin
    clk_sys_in = 0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  task step(input int n);
    repeat (n) @(posedge clk_sys_in);
    #5;
  endtask : step
  task chk(input logic [4:0] got, input logic [4:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task restart(input logic [2:0] g, input logic [4:0] m, input logic [1:0] s);
    oscillator_group_config_in = g;
    primary_mode_config_in = m;
    monitor_switch_config_in = s;
    restart_in = 1;
    step(1);
    restart_in = 0;
    step(2);
  endtask : restart
  task ticks(input int n);
    repeat (n) begin
      osc_tick_in = 1;
      step(2);
      osc_tick_in = 0;
      step(2);
    end
  endtask : ticks
  task mode(input logic [2:0] g, input logic [4:0] m, input logic [1:0] gain,
            input logic fast_internal_rc, input logic [1:0] pin, input logic rel);
    restart(g, m, 2'h2);
    chk(current_group_select_out, g);
    chk(next_group_select_out, g);
    chk(pll_gain_out, gain);
    chk(pll_from_fast_rc_out, fast_internal_rc);
    if (g == 3'h3 || g == 3'h7) chk(output_pin_function_out, pin);
    if (g == 3'h1) chk(fast_rc_run_out, 1);
    step(1);
    chk(clock_release_out, rel);
  endtask : mode
  task t_modes;
    mode(3'h7, 5'h01, 2'h1, 1, 2'h1, 1);
    mode(3'h7, 5'h0a, 2'h2, 1, 2'h1, 1);
    mode(3'h7, 5'h03, 2'h3, 1, 2'h1, 1);
    mode(3'h7, 5'h05, 2'h1, 0, 2'h0, 0);
    mode(3'h7, 5'h0f, 2'h3, 0, 2'h1, 1);
    mode(3'h3, 5'h0b, 2'h0, 0, 2'h2, 1);
    mode(3'h3, 5'h0c, 2'h0, 0, 2'h1, 1);
    mode(3'h3, 5'h09, 2'h0, 0, 2'h2, 1);
    mode(3'h3, 5'h08, 2'h0, 0, 2'h1, 1);
    mode(3'h3, 5'h02, 2'h0, 0, 2'h0, 0);
    mode(3'h3, 5'h00, 2'h0, 0, 2'h0, 0);
    mode(3'h1, 5'h03, 2'h0, 0, 2'h0, 1);
    mode(3'h2, 5'h01, 2'h0, 0, 2'h0, 1);
    mode(3'h0, 5'h0a, 2'h0, 0, 2'h0, 0);
    $display("test modes done");
  endtask : t_modes
  task t_startup;
    restart(3'h3, 5'h04, 2'h2);
    ticks(500);
    restart(3'h3, 5'h04, 2'h2);
    ticks(1023);
    chk(clock_release_out, 0);
    ticks(1);
    for (int i = 0; i < 8 && clock_release_out !== 1'b1; i++) step(1);
    chk(clock_release_out, 1);
    $display("test startup done");
  endtask : t_startup
  task t_slow_rc;
    power_up_timer_done_in = 1;
    restart(3'h3, 5'h0c, 2'h2);
    step(5);
    chk(slow_rc_run_out, 0);
    chk(switching_enabled_out, 0);
    chk(fail_safe_monitor_enabled_out, 0);
    watchdog_enable_in = 1;
    step(3);
    chk(slow_rc_run_out, 1);
    chk(slow_rc_timers_clock_out, 1);
    watchdog_enable_in = 0;
    restart(3'h3, 5'h0c, 2'h0);
    step(5);
    chk(fail_safe_monitor_enabled_out, 1);
    chk(slow_rc_run_out, 1);
    restart(3'h3, 5'h0c, 2'h1);
    step(5);
    chk(switching_enabled_out, 1);
    chk(slow_rc_run_out, 0);
    restart(3'h2, 5'h0c, 2'h2);
    step(5);
    chk(slow_rc_run_out, 1);
    $display("test slow rc done");
  endtask : t_slow_rc
  task t_lock_tune;
    restart(3'h7, 5'h01, 2'h2);
    pll_lock_raw_in = 1;
    step(4);
    chk(pll_lock_out, 1);
    pll_lock_raw_in = 0;
    step(4);
    chk(pll_lock_out, 0);
    rc_tune_field_in = 4'h8;
    tune_write_in = 1;
    step(1);
    tune_write_in = 0;
    step(3);
    chk(rc_tune_field_out, 4'h0);
    clock_edge_safe_in = 1;
    step(3);
    chk(rc_tune_field_out, 4'h8);
    clock_edge_safe_in = 0;
    $display("test lock and tune done");
  endtask : t_lock_tune
  task t_secondary;
    secondary_crystal_enable_in = 1;
    restart(3'h0, 5'h00, 2'h2);
    step(3);
    chk(secondary_crystal_run_out, 1);
    chk(secondary_crystal_is_clock_out, 1);
    restart(3'h1, 5'h00, 2'h2);
    step(3);
    chk(secondary_crystal_is_clock_out, 0);
    chk(secondary_crystal_run_out, 1);
    secondary_crystal_enable_in = 0;
    step(3);
    chk(secondary_crystal_run_out, 0);
    $display("test secondary done");
  endtask : t_secondary
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    #2000000;
    bad_count++;
    $display("BAD %0t run did not finish", $time);
    end_sim;
  end
  initial begin
    {rstn_in, restart_in, osc_tick_in, tune_write_in, watchdog_enable_in} = 0;
    {secondary_crystal_enable_in, pll_lock_raw_in, clock_edge_safe_in} = 0;
    {power_up_timer_done_in, oscillator_group_config_in} = 0;
    {primary_mode_config_in, monitor_switch_config_in, rc_tune_field_in} = 0;
    step(8);
    rstn_in = 1;
    chk(slow_rc_run_out, 1);
    chk(input_pin_gpio_out, 0);
    chk(rc_tune_field_out, 4'h0);
    t_modes;
    t_startup;
    t_slow_rc;
    t_lock_tune;
    t_secondary;
    end_sim;
  end
endmodule : oscillator_source_select_tb
`default_nettype wire
